// *** inc/picdr_consts.svh ***
`ifndef PICDR_CONSTS_SVH
`define PICDR_CONSTS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PICDR_REG_IRQ       5'h1b
`define PICDR_REG_DIAG      5'h1d
`define PICDR_REG_CTRL1     5'h1e

// ----------------------------------------
// field positions
// ----------------------------------------
`define PICDR_IRQ_EN_HI     15
`define PICDR_IRQ_EN_LO     8
`define PICDR_DIAG_RUN_BIT  15
`define PICDR_LED_HI        15
`define PICDR_LED_LO        14

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PICDR_RST_EN        8'h00
`define PICDR_RST_FLAGS     8'h00
`define PICDR_RST_RESULT    2'h0
`define PICDR_RST_COUNT     9'h000
`define PICDR_RST_LED       2'h0
`define PICDR_LED_ACT_LINK  2'h1
`define PICDR_OP_READ       2'h2
`define PICDR_OP_WRITE      2'h1

// ----------------------------------------
// serial frame layout
// ----------------------------------------
`define PICDR_PREAMBLE_LEN  6'h20
`define PICDR_HDR_LAST      5'h0c
`define PICDR_RD_BITS       5'h10
`define PICDR_WR_LAST       5'h11

`endif

// *** inc/picdr_pkg.sv ***
package picdr_pkg;

    typedef enum logic [2:0] {
        ST_PRE,
        ST_HDR,
        ST_TA_RD,
        ST_DATA_RD,
        ST_DATA_WR
    } picdr_state_e;

endpackage : picdr_pkg

// *** src/picdr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "picdr_consts.svh"

module picdr_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_n,
    input  wire logic [7:0] evt_in,
    output logic            irq,
    output logic            diag_start,
    input  wire logic       diag_done,
    input  wire logic [1:0] diag_result,
    input  wire logic [8:0] diag_count,
    input  wire logic       link_status,
    input  wire logic       activity,
    input  wire logic       speed_100,
    input  wire logic       polarity_rev,
    input  wire logic       far_end_fault,
    input  wire logic       mdix_state,
    output logic            indicator_out_a,
    output logic            indicator_out_b
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic                      mdc_s1_reg;
    logic                      mdc_s2_reg;
    logic                      mdc_s3_reg;
    logic                      mdio_s1_reg;
    logic                      mdio_s2_reg;
    picdr_pkg::picdr_state_e   state_reg;
    picdr_pkg::picdr_state_e   state_next;
    logic [5:0]                ones_reg;
    logic [5:0]                ones_next;
    logic [4:0]                cnt_reg;
    logic [4:0]                cnt_next;
    logic [15:0]               shift_reg;
    logic [15:0]               shift_next;
    logic [4:0]                addr_reg;
    logic [4:0]                addr_next;
    logic                      out_reg;
    logic                      out_next;
    logic                      oe_n_reg;
    logic                      oe_n_next;
    logic [7:0]                en_reg;
    logic [7:0]                en_next;
    logic [7:0]                flags_reg;
    logic [7:0]                flags_next;
    logic                      run_reg;
    logic                      run_next;
    logic [1:0]                result_reg;
    logic [1:0]                result_next;
    logic [8:0]                count_reg;
    logic [8:0]                count_next;
    logic [1:0]                led_reg;
    logic [1:0]                led_next;
    logic                      start_reg;
    logic                      start_next;
    logic                      irq_reg;
    logic                      irq_next;
    logic                      ind_a_reg;
    logic                      ind_a_next;
    logic                      ind_b_reg;
    logic                      ind_b_next;

    logic                      mdc_rise;
    logic                      bit_in;
    logic [12:0]               hdr;
    logic [15:0]               wdata;
    logic [15:0]               rdata;
    logic [7:0]                clr_mask;
    logic                      wr_en;

    assign mdc_rise = mdc_s2_reg & ~mdc_s3_reg;
    assign bit_in   = mdio_s2_reg;
    assign hdr      = {shift_reg[11:0], bit_in};
    assign wdata    = {shift_reg[14:0], bit_in};

    // ----------------------------------------
    // read value mux
    // ----------------------------------------
    always_comb begin
        case (hdr[4:0])
            `PICDR_REG_IRQ:   rdata = {en_reg, flags_reg};
            `PICDR_REG_DIAG:  rdata = {run_reg, result_reg, 4'h0, count_reg};
            `PICDR_REG_CTRL1: rdata = {led_reg, polarity_rev, far_end_fault,
                                       mdix_state, 11'h000};
            default:          rdata = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        state_next  = state_reg;
        ones_next   = ones_reg;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        addr_next   = addr_reg;
        out_next    = out_reg;
        oe_n_next   = oe_n_reg;
        en_next     = en_reg;
        run_next    = run_reg;
        result_next = result_reg;
        count_next  = count_reg;
        led_next    = led_reg;
        start_next  = 1'b0;
        clr_mask    = 8'h00;
        wr_en       = 1'b0;

        if (mdc_rise) begin
            case (state_reg)
                picdr_pkg::ST_PRE: begin
                    if (bit_in) begin
                        if (ones_reg != `PICDR_PREAMBLE_LEN) begin
                            ones_next = ones_reg + 6'h01;
                        end
                    end else begin
                        if (ones_reg == `PICDR_PREAMBLE_LEN) begin
                            state_next = picdr_pkg::ST_HDR;
                            cnt_next   = 5'h00;
                        end
                        ones_next = 6'h00;
                    end
                end
                picdr_pkg::ST_HDR: begin
                    shift_next = {shift_reg[14:0], bit_in};
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == `PICDR_HDR_LAST) begin
                        state_next = picdr_pkg::ST_PRE;
                        addr_next  = hdr[4:0];
                        if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
                            if (hdr[11:10] == `PICDR_OP_READ) begin
                                state_next = picdr_pkg::ST_TA_RD;
                                shift_next = rdata;
                                if (hdr[4:0] == `PICDR_REG_IRQ) begin
                                    clr_mask = 8'hff;
                                end
                            end else if (hdr[11:10] == `PICDR_OP_WRITE) begin
                                state_next = picdr_pkg::ST_DATA_WR;
                                cnt_next   = 5'h00;
                            end
                        end
                    end
                end
                picdr_pkg::ST_TA_RD: begin
                    oe_n_next  = 1'b0;
                    out_next   = 1'b0;
                    cnt_next   = 5'h00;
                    state_next = picdr_pkg::ST_DATA_RD;
                end
                picdr_pkg::ST_DATA_RD: begin
                    if (cnt_reg == `PICDR_RD_BITS) begin
                        oe_n_next  = 1'b1;
                        out_next   = 1'b0;
                        ones_next  = 6'h00;
                        state_next = picdr_pkg::ST_PRE;
                    end else begin
                        out_next   = shift_reg[15];
                        shift_next = {shift_reg[14:0], 1'b0};
                        cnt_next   = cnt_reg + 5'h01;
                    end
                end
                picdr_pkg::ST_DATA_WR: begin
                    shift_next = wdata;
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == `PICDR_WR_LAST) begin
                        wr_en      = 1'b1;
                        ones_next  = 6'h00;
                        state_next = picdr_pkg::ST_PRE;
                    end
                end
                default: begin
                    state_next = picdr_pkg::ST_PRE;
                end
            endcase
        end

        if (wr_en) begin
            case (addr_reg)
                `PICDR_REG_IRQ: begin
                    en_next = wdata[`PICDR_IRQ_EN_HI:`PICDR_IRQ_EN_LO];
                end
                `PICDR_REG_DIAG: begin
                    if (wdata[`PICDR_DIAG_RUN_BIT] && !run_reg) begin
                        run_next   = 1'b1;
                        start_next = 1'b1;
                    end
                end
                `PICDR_REG_CTRL1: begin
                    led_next = wdata[`PICDR_LED_HI:`PICDR_LED_LO];
                end
                default: begin
                end
            endcase
        end

        if (diag_done && run_reg) begin
            run_next    = 1'b0;
            result_next = diag_result;
            count_next  = diag_count;
        end

        // set wins over clear-on-read
        flags_next = (flags_reg & ~clr_mask) | evt_in;
        irq_next = |(en_reg & flags_reg);

        case (led_reg)
            `PICDR_LED_ACT_LINK: begin
                ind_a_next = link_status;
                ind_b_next = activity;
            end
            default: begin
                ind_a_next = link_status & ~activity;
                ind_b_next = speed_100;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mdc_s1_reg  <= 1'b0;
            mdc_s2_reg  <= 1'b0;
            mdc_s3_reg  <= 1'b0;
            mdio_s1_reg <= 1'b1;
            mdio_s2_reg <= 1'b1;
            state_reg   <= picdr_pkg::ST_PRE;
            ones_reg    <= 6'h00;
            cnt_reg     <= 5'h00;
            shift_reg   <= 16'h0000;
            addr_reg    <= 5'h00;
            out_reg     <= 1'b0;
            oe_n_reg    <= 1'b1;
            en_reg      <= `PICDR_RST_EN;
            flags_reg   <= `PICDR_RST_FLAGS;
            run_reg     <= 1'b0;
            result_reg  <= `PICDR_RST_RESULT;
            count_reg   <= `PICDR_RST_COUNT;
            led_reg     <= `PICDR_RST_LED;
            start_reg   <= 1'b0;
            irq_reg     <= 1'b0;
            ind_a_reg   <= 1'b0;
            ind_b_reg   <= 1'b0;
        end else begin
            mdc_s1_reg  <= mdc;
            mdc_s2_reg  <= mdc_s1_reg;
            mdc_s3_reg  <= mdc_s2_reg;
            mdio_s1_reg <= mdio_in;
            mdio_s2_reg <= mdio_s1_reg;
            state_reg   <= state_next;
            ones_reg    <= ones_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            addr_reg    <= addr_next;
            out_reg     <= out_next;
            oe_n_reg    <= oe_n_next;
            en_reg      <= en_next;
            flags_reg   <= flags_next;
            run_reg     <= run_next;
            result_reg  <= result_next;
            count_reg   <= count_next;
            led_reg     <= led_next;
            start_reg   <= start_next;
            irq_reg     <= irq_next;
            ind_a_reg   <= ind_a_next;
            ind_b_reg   <= ind_b_next;
        end
    end

    assign mdio_out        = out_reg;
    assign mdio_oe_n       = oe_n_reg;
    assign irq             = irq_reg;
    assign diag_start      = start_reg;
    assign indicator_out_a = ind_a_reg;
    assign indicator_out_b = ind_b_reg;

endmodule : picdr_regs
`default_nettype wire

// *** verification/picdr_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module picdr_regs_checker (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       mdc,
    input wire logic [7:0] evt_in,
    input wire logic       irq,
    input wire logic       diag_start,
    input wire logic       link_status,
    input wire logic       activity,
    input wire logic       speed_100,
    input wire logic       indicator_out_a,
    input wire logic       indicator_out_b
);
    logic [7:0] quiet_reg;
    logic [7:0] quiet_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // cycles since mdc last high
    always_comb begin
        quiet_next = (quiet_reg == 8'hff) ? quiet_reg : quiet_reg + 8'h01;
        if (mdc || !rst_n) begin
            quiet_next = mdc ? 8'h00 : 8'hff;
        end
    end
    always_ff @(posedge mclk) begin
        quiet_reg <= quiet_next;
    end
    property p_start_pulse;
        diag_start |=> !diag_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    property p_start_cause;
        diag_start |-> quiet_reg < 8'h0a;
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start no write");
    property p_irq_rise;
        $rose(irq) |-> $past(evt_in, 2) != 8'h00 || $past(evt_in, 3) != 8'h00
                       || quiet_reg < 8'h0a;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose no cause");
    property p_irq_fall;
        $fell(irq) |-> quiet_reg < 8'h0a;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell no read");
    property p_irq_quiet;
        (quiet_reg > 8'h08 && evt_in == 8'h00) [*4] |-> $stable(irq);
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq moved idle");
    property p_led_a_link;
        indicator_out_a |-> $past(link_status);
    endproperty
    a_led_a_link: assert property (p_led_a_link) else $error("led a no link");
    property p_led_a_on;
        $past(rst_n) && $past(link_status) && !$past(activity) |-> indicator_out_a;
    endproperty
    a_led_a_on: assert property (p_led_a_on) else $error("led a dark");
    property p_led_b;
        indicator_out_b |-> $past(speed_100) || $past(activity);
    endproperty
    a_led_b: assert property (p_led_b) else $error("led b no cause");
endmodule : picdr_regs_checker
bind picdr_regs picdr_regs_checker u_chk (
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .evt_in(evt_in), .irq(irq),
    .diag_start(diag_start), .link_status(link_status), .activity(activity),
    .speed_100(speed_100), .indicator_out_a(indicator_out_a),
    .indicator_out_b(indicator_out_b)
);
`default_nettype wire

// *** verification/picdr_station.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// management station model
// ----------------------------------------
module picdr_station (
    input  wire logic mclk,
    input  wire logic line,
    output logic      mdc,
    output logic      drv_en,
    output logic      drv_d
);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_d = 1'b1;
    end
    // one mdc period, 8 mclk, sample before rise
    task automatic clk_bit(input logic d, input logic en, output logic s);
        drv_en = en;
        drv_d = d;
        repeat (4) @(negedge mclk);
        s = line;
        mdc = 1'b1;
        repeat (4) @(negedge mclk);
        mdc = 1'b0;
    endtask : clk_bit
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic [45:0] h;
        logic        s;
        h = {32'hffff_ffff, 2'b01, op, pa, ra};
        rd = 16'h0000;
        for (int i = 45; i >= 0; i--) begin
            clk_bit(h[i], 1'b1, s);
        end
        if (op == 2'b01) begin
            clk_bit(1'b1, 1'b1, s);
            clk_bit(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) begin
                clk_bit(wd[i], 1'b1, s);
            end
        end else begin
            clk_bit(1'b1, 1'b0, s);
            clk_bit(1'b1, 1'b0, ta);
            for (int i = 15; i >= 0; i--) begin
                clk_bit(1'b1, 1'b0, rd[i]);
            end
        end
        drv_en = 1'b0;
        @(negedge mclk);
    endtask : xfer
endmodule : picdr_station
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "picdr_consts.svh"
module testbench;
    localparam logic [4:0] PA = 5'h05;
    logic       mclk, rst_n, mdc, mdio_in, mdio_out, mdio_oe_n, drv_en, drv_d, irq;
    logic       diag_start, diag_done, link_status, activity, speed_100, ind_a, ind_b;
    logic       polarity_rev, far_end_fault, mdix_state;
    logic [7:0] evt_in;
    logic [1:0] diag_result;
    logic [8:0] diag_count;
    int         n_errors, checked, n_start;
    // ----------------------------------------
    // pin with pull-up, design and station
    // ----------------------------------------
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_d : 1'b1);
    picdr_regs #(.PHY_ADDR(PA)) dut (
        .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .evt_in(evt_in), .irq(irq), .diag_start(diag_start),
        .diag_done(diag_done), .diag_result(diag_result), .diag_count(diag_count),
        .link_status(link_status), .activity(activity), .speed_100(speed_100),
        .polarity_rev(polarity_rev), .far_end_fault(far_end_fault),
        .mdix_state(mdix_state), .indicator_out_a(ind_a), .indicator_out_b(ind_b)
    );
    picdr_station stn (.mclk(mclk), .line(mdio_in), .mdc(mdc), .drv_en(drv_en), .drv_d(drv_d));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (diag_start === 1'b1) n_start <= n_start + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        logic        t;
        stn.xfer(`PICDR_OP_WRITE, PA, ra, d, x, t);
    endtask : wr
    task automatic rchk(input string w, input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] d;
        logic        t;
        stn.xfer(`PICDR_OP_READ, PA, ra, 16'h0000, d, t);
        check(w, d, e);
    endtask : rchk
    task automatic test_done;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [15:0] d;
        logic        t;
        rchk("irq_reg", `PICDR_REG_IRQ, 16'h0000);
        rchk("diag_reg", `PICDR_REG_DIAG, 16'h0000);
        stn.xfer(`PICDR_OP_WRITE, PA + 5'h01, `PICDR_REG_CTRL1, 16'h4000, d, t);
        rchk("ctrl1_kept", `PICDR_REG_CTRL1, 16'h0000);
    endtask : t_reset
    task automatic t_irq;
        for (int i = 0; i < 8; i++) begin
            wr(`PICDR_REG_IRQ, 16'h0100 << i);
            evt_in = 8'h01 << i;
            cyc(1);
            evt_in = 8'h00;
            cyc(3);
            check("irq_on", {15'h0000, irq}, 16'h0001);
            rchk("irq_bit", `PICDR_REG_IRQ, 16'h0101 << i);
            check("irq_off", {15'h0000, irq}, 16'h0000);
        end
        wr(`PICDR_REG_IRQ, 16'h0000);
        evt_in = 8'hff;
        cyc(1);
        evt_in = 8'h00;
        cyc(3);
        check("irq_mask", {15'h0000, irq}, 16'h0000);
        rchk("irq_all", `PICDR_REG_IRQ, 16'h00ff);
        rchk("irq_clr", `PICDR_REG_IRQ, 16'h0000);
    endtask : t_irq
    task automatic pulse_done;
        diag_done = 1'b1;
        cyc(1);
        diag_done = 1'b0;
        cyc(2);
    endtask : pulse_done
    task automatic t_diag;
        logic [8:0]  cnt [4];
        logic [15:0] last;
        int          s0;
        cnt = '{9'h1ff, 9'h000, 9'h0a5, 9'h100};
        last = 16'h0000;
        diag_result = 2'h3;
        pulse_done;
        rchk("diag_idle", `PICDR_REG_DIAG, last);
        for (int c = 0; c < 4; c++) begin
            s0 = n_start;
            wr(`PICDR_REG_DIAG, 16'hffff);
            check("start", 16'(n_start - s0), 16'h0001);
            rchk("diag_run", `PICDR_REG_DIAG, last | 16'h8000);
            wr(`PICDR_REG_DIAG, 16'hffff);
            check("restart", 16'(n_start - s0), 16'h0001);
            diag_result = c[1:0];
            diag_count = cnt[c];
            pulse_done;
            last = {1'b0, c[1:0], 4'h0, cnt[c]};
            rchk("diag_res", `PICDR_REG_DIAG, last);
        end
    endtask : t_diag
    task automatic t_led;
        logic [1:0] m;
        logic [2:0] v;
        logic       ea, eb;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            {polarity_rev, far_end_fault, mdix_state} = {m[0], m[1], ~m[0]};
            wr(`PICDR_REG_CTRL1, {m, 14'h0000});
            rchk("ctrl1", `PICDR_REG_CTRL1, {m, m[0], m[1], ~m[0], 11'h000});
            for (int j = 0; j < 8; j++) begin
                v = j[2:0];
                {link_status, activity, speed_100} = v;
                cyc(3);
                ea = (m == `PICDR_LED_ACT_LINK) ? v[2] : v[2] & ~v[1];
                eb = (m == `PICDR_LED_ACT_LINK) ? v[1] : v[0];
                check("leds", {14'h0000, ind_a, ind_b}, {14'h0000, ea, eb});
            end
        end
    endtask : t_led
    initial begin
        n_errors = 0;
        checked = 0;
        rst_n = 1'b0;
        evt_in = 8'h00;
        diag_done = 1'b0;
        diag_result = 2'h0;
        diag_count = 9'h000;
        {link_status, activity, speed_100} = 3'h0;
        {polarity_rev, far_end_fault, mdix_state} = 3'h0;
        cyc(20);
        rst_n = 1'b1;
        cyc(4);
        t_reset;
        t_irq;
        t_diag;
        t_led;
        test_done;
    end
    initial begin
        #3_000_000;
        n_errors++;
        test_done;
    end
endmodule : testbench
`default_nettype wire
